/* src/spr_regs.vh */
// Register offsets, field positions and reset values of the sleep and power reduction block
`ifndef SPR_REGS_VH
`define SPR_REGS_VH
`define SPR_OFF_SLEEP 8'h00
`define SPR_OFF_MCU 8'h04
`define SPR_OFF_POWER 8'h08
`define SPR_OFF_SLEEP_CMD 8'h0C
`define SPR_OFF_STATUS 8'h10
`define SPR_ADDR_W 8
`define SPR_BIT_SE 0
`define SPR_BIT_SM_LO 1
`define SPR_BIT_SM_HI 2
`define SPR_BIT_BROWNOUT_SLEEP_BIT 6
`define SPR_BIT_BROWNOUT_SLEEP_UNLOCK 5
`define SPR_BIT_PUD 4
`define SPR_BIT_TWI 7
`define SPR_BIT_TIM0 5
`define SPR_BIT_TIM1 3
`define SPR_BIT_SPI 2
`define SPR_BIT_ADC 0
`define SPR_SLEEP_MASK 8'h07
`define SPR_MCU_MASK 8'h70
`define SPR_POWER_MASK 8'hAD
`define SPR_RESET_BYTE 8'h00
`define SPR_SM_IDLE 2'h0
`define SPR_SM_NOISE 2'h1
`define SPR_SM_PDOWN 2'h2
`define SPR_SM_RSVD 2'h3
`define SPR_UNLOCK_CYCLES 3'h4
`define SPR_BROWNOUT_SLEEP_BIT_DELAY 2'h3
`define SPR_BROWNOUT_SLEEP_BIT_LIFE 3'h3
`define SPR_WAKE_HALT 3'h4
`define SPR_HTRANS_NONSEQ 2'h2
`endif

/* src/spr_ctrl.v */
// Sleep mode control, timed brown-out sleep disable and peripheral power reduction
//
// What this block does
// - Sleep register bits seven to three read zero
// - Select field: idle, noise reduction, power-down
// - Sleep command sleeps only with enable set
// - MCU register holds brownout_sleep_bit, unlock, pull-up
// - Brownout_sleep_bit set by unlock then set write
// - Brownout_sleep_bit effective three cycles after setting
// - Brownout_sleep_bit self-clears three cycles after taking effect
// - Detector off only if sleeping while active
// - Power bit stops clock, blocks register access
// - Clearing power bit resumes peripheral unchanged
// - Power bits map twowire, timers, spi, adc
// - Comparator unavailable while converter gated off
// - Peripheral gating acts in active and idle
// - Input buffers off when io, adc stopped
// - Comparator off in deep sleep; reference kept
// - Converter stays enabled; next conversion extended
// - Enabled watchdog keeps running while asleep
// - Debug fuse keeps main clock running asleep
// - Fused detector stays on unless brownout_sleep_bit used
// - Clock domains stopped per selected mode
// - Wake halts cpu four extra cycles
// - Software detector disable only in power-down
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "spr_regs.vh"

module spr_ctrl #(
	parameter [2:0] UNLOCK_CYCLES = `SPR_UNLOCK_CYCLES, // Length of the unlock window
	parameter [2:0] BROWNOUT_SLEEP_BIT_DELAY = {1'b0, `SPR_BROWNOUT_SLEEP_BIT_DELAY}, // Set write to effective, cycles
	parameter [2:0] BROWNOUT_SLEEP_BIT_LIFE = `SPR_BROWNOUT_SLEEP_BIT_LIFE, // Effective to self-clear, cycles
	parameter [2:0] WAKE_HALT = `SPR_WAKE_HALT // Extra halt cycles after start-up
) (
	input wire clk, // System clock, 100 MHz
	input wire reset_n, // Synchronous reset, active low
	input wire hsel, // AHB slave select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output wire hreadyout, // AHB slave ready
	output wire hresp, // AHB response, always OKAY
	output reg [31:0] hrdata, // AHB read data
	input wire sleep_instr, // One-cycle pulse: CPU executes sleep
	input wire wake_event, // Enabled interrupt or wake source
	input wire startup_done, // Clock start-up time elapsed
	input wire adc_enabled, // Converter enable from its control reg
	input wire comp_enabled, // Comparator enable from its control reg
	input wire comp_uses_ref, // Comparator uses internal reference
	input wire wdt_enabled, // Watchdog enabled
	input wire debug_enable_fuse, // On-chip debug enabled
	input wire brownout_level_fuses, // Detector enabled by fuses
	input wire wake_pin_needed, // Some input needed to detect wake
	output reg sleeping, // Device in a sleep mode
	output reg cpu_halted, // CPU and flash clocks stopped
	output wire clk_cpu_en, // CPU clock enable
	output wire clk_flash_en, // Flash clock enable
	output wire clk_io_en, // I/O clock enable
	output wire clk_adc_en, // ADC clock enable
	output wire main_osc_en, // Main clock source enable
	output wire wdt_run, // Watchdog runs
	output wire brownout_on, // Brown-out detector powered
	output wire brownout_sleep_active, // Brown-out sleep bit effective
	output wire pullup_disable, // Global pull-up disable
	output wire twowire_clk_en, // Two-wire unit clock enable
	output wire timer0_clk_en, // Timer 0 clock enable
	output wire timer1_clk_en, // Timer 1 clock enable
	output wire spi_clk_en, // SPI clock enable
	output wire adc_gated_clk_en, // Converter clock enable
	output wire [4:0] periph_access_ok, // Register access allowed: twi,t0,t1,spi,adc
	output wire comparator_on, // Comparator powered
	output wire int_ref_on, // Internal reference powered
	output wire adc_on, // Converter powered
	output reg adc_extended_next, // Next conversion is extended
	output wire input_buf_en, // General digital input buffer enable
	output wire wake_buf_en // Wake-detect input buffer enable
);

	// ==========================================================
	// Bus slave
	reg [`SPR_ADDR_W-1:0] a_addr;
	reg a_wr;
	reg a_rd;
	wire take = hsel && hready && (htrans == `SPR_HTRANS_NONSEQ);
	// Zero wait states: every access completes in its first data cycle
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always @(posedge clk) begin
		if (!reset_n) begin
			a_addr <= {`SPR_ADDR_W{1'b0}};
			a_wr <= 1'b0;
			a_rd <= 1'b0;
		end else begin
			a_wr <= take && hwrite;
			a_rd <= take && !hwrite;
			if (take)
				a_addr <= haddr[`SPR_ADDR_W-1:0];
		end
	end

	wire [7:0] wbyte = hwdata[7:0];
	wire wr_sleep = a_wr && (a_addr == `SPR_OFF_SLEEP);
	wire wr_mcu = a_wr && (a_addr == `SPR_OFF_MCU);
	wire wr_power = a_wr && (a_addr == `SPR_OFF_POWER);

	// ==========================================================
	// Input synchronisers
	// Wake and start-up come from other clock sources. A level counts only once
	// the last two stages agree, so a wake source must be held for a few cycles.
	reg [2:0] wake_sync;
	reg [2:0] start_sync;
	reg wake_seen;
	reg start_seen;

	always @(posedge clk) begin
		if (!reset_n) begin
			wake_sync <= 3'h0;
			start_sync <= 3'h0;
			wake_seen <= 1'b0;
			start_seen <= 1'b0;
		end else begin
			wake_sync <= {wake_sync[1:0], wake_event};
			start_sync <= {start_sync[1:0], startup_done};
			if (wake_sync[1] == wake_sync[2])
				wake_seen <= wake_sync[2];
			if (start_sync[1] == start_sync[2])
				start_seen <= start_sync[2];
		end
	end

	// ==========================================================
	// Registers
	reg [7:0] sleep_mode_control;
	reg [7:0] power_reduction;
	reg pullup_bit;
	reg unlock_bit;
	reg brownout_sleep_bit;
	reg [2:0] unlock_cnt;
	reg [2:0] brownout_sleep_bit_age;
	reg adc_was_on;

	wire sleep_enable_bit = sleep_mode_control[`SPR_BIT_SE];
	wire [1:0] sleep_select_field = sleep_mode_control[`SPR_BIT_SM_HI:`SPR_BIT_SM_LO];
	wire w_brownout_sleep_bit = wbyte[`SPR_BIT_BROWNOUT_SLEEP_BIT];
	wire w_brownout_sleep_unlock = wbyte[`SPR_BIT_BROWNOUT_SLEEP_UNLOCK];
	wire window_open = unlock_cnt != 3'h0;

	always @(posedge clk) begin
		if (!reset_n) begin
			sleep_mode_control <= `SPR_RESET_BYTE;
			power_reduction <= `SPR_RESET_BYTE;
			pullup_bit <= 1'b0;
			unlock_bit <= 1'b0;
			brownout_sleep_bit <= 1'b0;
			unlock_cnt <= 3'h0;
			brownout_sleep_bit_age <= 3'h0;
		end else begin
			if (wr_sleep)
				sleep_mode_control <= wbyte & `SPR_SLEEP_MASK;
			if (wr_power)
				power_reduction <= wbyte & `SPR_POWER_MASK;
			if (wr_mcu)
				pullup_bit <= wbyte[`SPR_BIT_PUD];
			// Unlock write opens a window of four cycles
			if (wr_mcu && w_brownout_sleep_bit && w_brownout_sleep_unlock) begin
				unlock_bit <= 1'b1;
				unlock_cnt <= UNLOCK_CYCLES;
			end else if (window_open) begin
				unlock_cnt <= unlock_cnt - 3'h1;
				unlock_bit <= (unlock_cnt != 3'h1) && !(wr_mcu && !w_brownout_sleep_unlock);
				if (wr_mcu && !w_brownout_sleep_unlock)
					unlock_cnt <= 3'h0;
			end else begin
				unlock_bit <= 1'b0;
			end
			// Only a set write inside the window lands; late ones are dropped
			if (wr_mcu && w_brownout_sleep_bit && !w_brownout_sleep_unlock && window_open) begin
				brownout_sleep_bit <= 1'b1;
				brownout_sleep_bit_age <= 3'h1;
			end else if (brownout_sleep_bit) begin
				if (brownout_sleep_bit_age == BROWNOUT_SLEEP_BIT_DELAY + BROWNOUT_SLEEP_BIT_LIFE) begin
					brownout_sleep_bit <= 1'b0;
					brownout_sleep_bit_age <= 3'h0;
				end else begin
					brownout_sleep_bit_age <= brownout_sleep_bit_age + 3'h1;
				end
			end
		end
	end

	// Bit is readable at once but effective only after three cycles
	assign brownout_sleep_active = brownout_sleep_bit && (brownout_sleep_bit_age > BROWNOUT_SLEEP_BIT_DELAY);
	assign pullup_disable = pullup_bit;

	// ==========================================================
	// Sleep sequencer
	localparam ST_RUN = 3'b001;
	localparam ST_SLEEP = 3'b010;
	localparam ST_WAKE = 3'b100;
	reg [2:0] state;
	reg [1:0] mode;
	reg bod_off;
	reg [2:0] halt_cnt;

	always @(posedge clk) begin
		if (!reset_n) begin
			state <= ST_RUN;
			mode <= `SPR_SM_IDLE;
			bod_off <= 1'b0;
			halt_cnt <= 3'h0;
			sleeping <= 1'b0;
			cpu_halted <= 1'b0;
		end else begin
			case (state)
			ST_RUN: begin
				// Reserved select code is ignored
				if (sleep_instr && sleep_enable_bit && sleep_select_field != `SPR_SM_RSVD) begin
					state <= ST_SLEEP;
					mode <= sleep_select_field;
					sleeping <= 1'b1;
					cpu_halted <= 1'b1;
					bod_off <= brownout_sleep_active &&
						(sleep_select_field == `SPR_SM_PDOWN);
				end
			end
			ST_SLEEP: begin
				if (wake_seen) begin
					state <= ST_WAKE;
					bod_off <= 1'b0;
					sleeping <= 1'b0;
					halt_cnt <= WAKE_HALT;
				end
			end
			ST_WAKE: begin
				// Halt runs four cycles past clock start-up
				if (start_seen) begin
					if (halt_cnt == 3'h1) begin
						state <= ST_RUN;
						cpu_halted <= 1'b0;
					end
					halt_cnt <= halt_cnt - 3'h1;
				end
			end
			default: begin
				state <= ST_RUN;
				sleeping <= 1'b0;
				cpu_halted <= 1'b0;
			end
			endcase
		end
	end

	// ==========================================================
	// Clock domains
	wire asleep = state == ST_SLEEP;
	wire deep = asleep && (mode == `SPR_SM_PDOWN);
	wire io_stop = asleep && (mode != `SPR_SM_IDLE);
	assign clk_cpu_en = !cpu_halted;
	assign clk_flash_en = !cpu_halted;
	assign clk_io_en = !io_stop;
	assign clk_adc_en = !deep;
	assign main_osc_en = !deep || debug_enable_fuse;
	assign wdt_run = wdt_enabled;
	assign brownout_on = brownout_level_fuses && !bod_off;

	// Gating by power bits rides on the io clock (the adc clock for the converter), so it matters only when that runs
	// Order of each vector: twowire, timer 0, timer 1, spi, converter
	wire [4:0] power_bits = {power_reduction[`SPR_BIT_TWI], power_reduction[`SPR_BIT_TIM0],
		power_reduction[`SPR_BIT_TIM1], power_reduction[`SPR_BIT_SPI],
		power_reduction[`SPR_BIT_ADC]};
	wire [4:0] domain_run = {clk_io_en, clk_io_en, clk_io_en, clk_io_en, clk_adc_en};
	wire [4:0] gated_en;
	genvar g;

	generate
		for (g = 0; g < 5; g = g + 1) begin : g_gate
			assign gated_en[g] = domain_run[g] && !power_bits[g];
		end
	endgenerate

	assign twowire_clk_en = gated_en[4];
	assign timer0_clk_en = gated_en[3];
	assign timer1_clk_en = gated_en[2];
	assign spi_clk_en = gated_en[1];
	assign adc_gated_clk_en = gated_en[0];
	assign periph_access_ok = ~power_bits;

	// ==========================================================
	// Analog and input buffers
	assign adc_on = adc_enabled;
	assign comparator_on = comp_enabled && !power_reduction[`SPR_BIT_ADC] && !deep;
	assign int_ref_on = (comp_enabled && comp_uses_ref) || adc_enabled ||
		(brownout_level_fuses && !bod_off);
	assign input_buf_en = !(io_stop && deep);
	assign wake_buf_en = input_buf_en || wake_pin_needed;

	always @(posedge clk) begin
		if (!reset_n) begin
			adc_was_on <= 1'b0;
			adc_extended_next <= 1'b1;
		end else begin
			adc_was_on <= adc_enabled;
			if (adc_was_on && !adc_enabled)
				adc_extended_next <= 1'b1;
			else if (adc_enabled && !adc_was_on)
				adc_extended_next <= 1'b1;
		end
	end

	// ==========================================================
	// Read mux
	wire [7:0] mcu_rd = {1'b0, brownout_sleep_bit, unlock_bit, pullup_bit, 4'h0};
	reg [31:0] next_hrdata;

	always @* begin
		next_hrdata = 32'h00000000;
		case (haddr[`SPR_ADDR_W-1:0])
		`SPR_OFF_SLEEP: next_hrdata = {24'h000000, sleep_mode_control & `SPR_SLEEP_MASK};
		`SPR_OFF_MCU: next_hrdata = {24'h000000, mcu_rd};
		`SPR_OFF_POWER: next_hrdata = {24'h000000, power_reduction & `SPR_POWER_MASK};
		`SPR_OFF_STATUS: next_hrdata = {24'h000000, 3'h0, state, sleeping, brownout_sleep_active};
		default: next_hrdata = 32'h00000000;
		endcase
	end

	// Data is captured at the address phase so it stands through the data phase
	always @(posedge clk) begin
		if (!reset_n) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end

endmodule // spr_ctrl

/* tb/spr_ctrl_properties.sv */
// Concurrent checks on the ports of the sleep and power reduction controller
`timescale 1ns/1ps
module spr_ctrl_properties (
	input wire clk, // Clock
	input wire reset_n, // Reset
	input wire sleeping, // Asleep
	input wire clk_cpu_en, // CPU clock
	input wire clk_io_en, // I/O clock
	input wire clk_adc_en, // ADC clock
	input wire main_osc_en, // Oscillator
	input wire debug_enable_fuse, // Debug fuse
	input wire wdt_enabled, // Watchdog on
	input wire wdt_run, // Watchdog runs
	input wire brownout_sleep_active, // Brownout_sleep_bit live
	input wire brownout_level_fuses, // Detector fused
	input wire brownout_on, // Detector on
	input wire [4:0] periph_access_ok, // Access
	input wire adc_gated_clk_en, // Converter clock
	input wire comparator_on // Comparator
);
	// ==========
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_cpu; sleeping |-> !clk_cpu_en; endproperty
	a_cpu: assert property (p_cpu) else $error("cpu clock runs asleep");
	property p_wdt; wdt_run == wdt_enabled; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog run wrong");
	property p_osc; sleeping && debug_enable_fuse |-> main_osc_en; endproperty
	a_osc: assert property (p_osc) else $error("oscillator off with debug");
	property p_gate; !periph_access_ok[0] |-> !adc_gated_clk_en; endproperty
	a_gate: assert property (p_gate) else $error("gated converter clock runs");
	property p_comp; !periph_access_ok[0] |-> !comparator_on; endproperty
	a_comp: assert property (p_comp) else $error("comparator on while gated");
	// A short life: the bit must vanish soon after it turns live
	property p_life; $rose(brownout_sleep_active) |-> ##[1:4] !brownout_sleep_active; endproperty
	a_life: assert property (p_life) else $error("brownout_sleep_bit did not clear");
	property p_bod;
		!sleeping && !$past(sleeping) && brownout_level_fuses |-> brownout_on;
	endproperty
	a_bod: assert property (p_bod) else $error("detector off while awake");
	property p_deep; sleeping && !clk_io_en && !clk_adc_en |-> !comparator_on; endproperty
	a_deep: assert property (p_deep) else $error("comparator on in power-down");
	c_sleep: cover property (sleeping && !clk_adc_en);
	c_brownout_sleep_bit: cover property ($rose(brownout_sleep_active));
	c_gate: cover property (!periph_access_ok[0]);
endmodule // spr_ctrl_properties

bind spr_ctrl spr_ctrl_properties i_spr_ctrl_properties (.clk, .reset_n, .sleeping, .clk_cpu_en,
	.clk_io_en, .clk_adc_en, .main_osc_en, .debug_enable_fuse, .wdt_enabled, .wdt_run,
	.brownout_sleep_active, .brownout_level_fuses, .brownout_on, .periph_access_ok,
	.adc_gated_clk_en, .comparator_on);

/* tb/spr_ctrl_tb_top.sv */
// Self-checking bench for the sleep and power reduction controller
`timescale 1ns/1ps
`include "spr_regs.vh"
module spr_ctrl_tb_top;
	reg clk = 0, reset_n = 0, hsel = 0, hwrite = 0, sleep_instr = 0, wake_event = 0;
	reg startup_done = 1, adc_enabled = 0, comp_enabled = 1, comp_uses_ref = 0, wdt_enabled = 1;
	reg debug_enable_fuse = 0, brownout_level_fuses = 1, wake_pin_needed = 0;
	reg [31:0] haddr = 0, hwdata = 0, rd;
	reg [1:0] htrans = 0, md;
	reg [2:0] hsize = 3'h2;
	wire hreadyout, sleeping, cpu_halted, clk_cpu_en, clk_io_en, clk_adc_en, main_osc_en;
	wire hresp, clk_flash_en, int_ref_on, adc_on, adc_extended_next, wake_buf_en;
	wire brownout_on, brownout_sleep_active, pullup_disable, comparator_on, input_buf_en;
	wire twowire_clk_en, timer0_clk_en, timer1_clk_en, spi_clk_en, adc_gated_clk_en;
	wire [31:0] hrdata;
	wire [4:0] periph_access_ok;
	integer n_mismatch = 0, checks = 0, k, n;
	spr_ctrl i_spr_ctrl (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleep_instr, .wake_event,
		.startup_done, .adc_enabled, .comp_enabled, .comp_uses_ref, .wdt_enabled,
		.debug_enable_fuse, .brownout_level_fuses, .wake_pin_needed, .sleeping, .cpu_halted,
		.clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_adc_en, .main_osc_en, .wdt_run(),
		.brownout_on, .brownout_sleep_active, .pullup_disable, .twowire_clk_en, .timer0_clk_en,
		.timer1_clk_en, .spi_clk_en, .adc_gated_clk_en, .periph_access_ok, .comparator_on,
		.int_ref_on, .adc_on, .adc_extended_next, .input_buf_en, .wake_buf_en);
	// =====
	// Tasks
	task chk(input [39:0] got, input [39:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Single word transfer; the bus is zero-wait, but ready is still honoured
	task ahb(input w, input [7:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			haddr <= {24'h000000, a};
			htrans <= `SPR_HTRANS_NONSEQ;
			hwrite <= w;
			@(posedge clk);
			while (hreadyout !== 1'b1) @(posedge clk);
			htrans <= 2'h0;
			hsel <= 1'b0;
			hwdata <= d;
			@(posedge clk);
			while (hreadyout !== 1'b1) @(posedge clk);
			rd = hrdata;
		end
	endtask
	task wait_brownout_sleep_bit;
		begin
			ahb(1'b1, `SPR_OFF_MCU, 32'h60);
			ahb(1'b1, `SPR_OFF_MCU, 32'h40);
			n = 0;
			while (brownout_sleep_active !== 1'b1 && n < 8) begin
				@(posedge clk);
				n = n + 1;
			end
			chk(brownout_sleep_active, 1);
			chk(n, `SPR_BROWNOUT_SLEEP_BIT_DELAY + 1);
		end
	endtask
	task pulse_sleep;
		begin
			sleep_instr <= 1'b1;
			@(posedge clk);
			sleep_instr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task tally_and_finish;
		begin
			if (n_mismatch == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial forever #5 clk = ~clk;
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		tally_and_finish;
	end
	// =====
	// Tests
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (k = 0; k < 4; k = k + 1) begin
			ahb(1'b0, {k[5:0], 2'h0}, 32'h0);
			chk({rd, hresp}, 33'h0);
		end
		ahb(1'b1, `SPR_OFF_SLEEP, 32'hFF);
		ahb(1'b0, `SPR_OFF_SLEEP, 32'h0);
		chk(rd, 32'h07);
		ahb(1'b1, `SPR_OFF_MCU, 32'h9F);
		ahb(1'b0, `SPR_OFF_MCU, 32'h0);
		chk({rd, pullup_disable}, {32'h10, 1'b1});
		ahb(1'b1, `SPR_OFF_POWER, 32'hFF);
		ahb(1'b0, `SPR_OFF_POWER, 32'h0);
		chk(rd, 32'hAD);
		chk({twowire_clk_en, timer0_clk_en, timer1_clk_en, spi_clk_en, periph_access_ok}, 0);
		chk({adc_gated_clk_en, comparator_on}, 0);
		ahb(1'b1, `SPR_OFF_POWER, 32'hA0);
		@(posedge clk);
		chk(periph_access_ok, 5'h07);
		ahb(1'b1, `SPR_OFF_POWER, 32'h0D);
		@(posedge clk);
		chk(periph_access_ok, 5'h18);
		ahb(1'b1, `SPR_OFF_POWER, 32'h0);
		@(posedge clk);
		chk({periph_access_ok, adc_gated_clk_en, comparator_on}, 7'h7F);
		ahb(1'b1, 8'h40, 32'hFF);
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		wait_brownout_sleep_bit;
		n = 0;
		while (brownout_sleep_active === 1'b1 && n < 8) begin
			@(posedge clk);
			n = n + 1;
		end
		chk(n, `SPR_BROWNOUT_SLEEP_BIT_LIFE);
		ahb(1'b1, `SPR_OFF_MCU, 32'h60);
		repeat (6) @(posedge clk);
		ahb(1'b1, `SPR_OFF_MCU, 32'h40);
		ahb(1'b0, `SPR_OFF_MCU, 32'h0);
		chk({rd, brownout_sleep_active}, 33'h0);
		adc_enabled <= 1'b1;
		chk(adc_extended_next, 1);
		repeat (2) @(posedge clk);
		chk({adc_on, adc_extended_next}, 2'h3);
		adc_enabled <= 1'b0;
		ahb(1'b1, `SPR_OFF_SLEEP, 32'h04);
		pulse_sleep;
		chk(sleeping, 0);
		for (k = 0; k < 5; k = k + 1) begin
			md = (k == 4) ? 2'h2 : k[1:0];
			debug_enable_fuse <= (k == 4);
			wdt_enabled <= k[0];
			wake_pin_needed <= (k == 2);
			comp_uses_ref <= (k == 4);
			ahb(1'b1, `SPR_OFF_SLEEP, {29'h0, md, 1'b1});
			wait_brownout_sleep_bit;
			pulse_sleep;
			chk(sleeping, md != 2'h3);
			if (md != 2'h3) begin
				chk({clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en},
					{2'b00, md == 2'h0, md != 2'h2});
				chk(wake_buf_en, md != 2'h2 || k == 2);
				chk(int_ref_on, md != 2'h2 || k == 4);
				chk(main_osc_en, md != 2'h2 || k == 4);
				chk({brownout_on, comparator_on, input_buf_en}, {3{md != 2'h2}});
				// Wake is a held level, dropped once sleeping reads low
				wake_event <= 1'b1;
				n = 0;
				while (cpu_halted !== 1'b0 && n < 40) begin
					@(posedge clk);
					n = n + 1;
					if (sleeping === 1'b0)
						wake_event <= 1'b0;
				end
				// Four synchroniser cycles, one to leave sleep, the halt, one to sample
				chk(n, `SPR_WAKE_HALT + 6);
				chk({sleeping, clk_cpu_en, brownout_on}, 3'h3);
			end
			ahb(1'b1, `SPR_OFF_SLEEP, 32'h0);
		end
		tally_and_finish;
	end
endmodule // spr_ctrl_tb_top
